// ===== port_traffic_mirror_tb_top.sv
// self-checking bench for the port traffic mirror
`timescale 1ns/1ps
`default_nettype none
module port_traffic_mirror_tb_top;
   import ptm_pkg::*;
   logic                 clk = 1'b0, reset_n = 1'b0;
   logic [ADDR_W-1:0]    s_axi_awaddr = '0, s_axi_araddr = '0;
   logic                 s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic                 s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [31:0]          s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0]           s_axi_wstrb = 4'hf;
   logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]           s_axi_bresp, s_axi_rresp;
   logic                 rxValid = 1'b0, rxLast = 1'b1, rxError = 1'b0, rxReady;
   logic [DATA_W-1:0]    rxData = '0, txData, gotData;
   logic [PORT_W-1:0]    rxSrcPort = '0, txSrcPort, gotSrc;
   logic                 txValid, txReady, txLast, txError, gotBeat, gotErr, gotLast;
   logic                 slow = 1'b0, stall = 1'b0;
   logic [NUM_PORTS-1:0] txMirrorMask, gotMask;
   int                   n_errors = 0, check_count = 0, acc;

   ptm_top DUT (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .rxValid, .rxReady, .rxData, .rxSrcPort, .rxLast, .rxError, .txValid,
      .txReady, .txData, .txSrcPort, .txLast, .txError, .txMirrorMask);
   ptm_sink_model sink (.clk, .reset_n, .slow, .stall, .txValid, .txReady, .txData, .txSrcPort,
      .txLast, .txError, .txMirrorMask, .gotBeat, .gotData, .gotSrc, .gotLast, .gotErr, .gotMask);

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] cmd(input ptm_op_t op, input int s, input int d, input bit e);
      return {17'h0, op, 3'h0, e, 1'b0, d[2:0], 1'b0, s[2:0]};
   endfunction

   // both channels offered together; each released once its own handshake is sampled
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw, w, b;
      logic [1:0] r;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(negedge clk);
         aw = s_axi_awvalid && s_axi_awready;
         w  = s_axi_wvalid && s_axi_wready;
         b  = s_axi_bvalid;
         r  = s_axi_bresp;
         @(posedge clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!b);
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [1:0] er, input logic [31:0] exp,
                        input logic [31:0] msk);
      bit ar, v;
      logic [1:0] r;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge clk);
         ar = s_axi_arvalid && s_axi_arready;
         v  = s_axi_rvalid;
         r  = s_axi_rresp;
         rd = s_axi_rdata;
         @(posedge clk);
         if (ar) s_axi_arvalid <= 1'b0;
      end while (!v);
      chk("rresp", {30'h0, er}, {30'h0, r});
      chk("rdata", exp & msk, rd & msk);
   endtask

   task automatic waitBeat();
      do begin
         @(negedge clk);
      end while (gotBeat !== 1'b1);
   endtask

   task automatic beat(input int s, input logic [7:0] d, input logic e, input logic [7:0] m);
      bit t;
      @(posedge clk);
      rxValid   <= 1'b1;
      rxSrcPort <= s[2:0];
      rxData    <= d;
      rxError   <= e;
      do begin
         @(negedge clk);
         t = rxReady;
         @(posedge clk);
      end while (!t);
      rxValid <= 1'b0;
      waitBeat();
      chk("mask", {24'h0, m}, {24'h0, gotMask});
      chk("beat", {19'h0, 1'b1, e, s[2:0], d}, {19'h0, gotLast, gotErr, gotSrc, gotData});
   endtask

   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      slow    <= 1'b1;
      rdChk(REG_CTRL, RESP_OKAY, 32'h4, 32'hffffffff);
      rdChk(REG_ERRMAP, RESP_OKAY, 32'hff, 32'hff);
      rdChk(8'h18, RESP_SLVERR, 32'h0, 32'h0);
      axiWr(REG_STAT, 32'h1, RESP_SLVERR);
      axiWr(REG_CMD, cmd(OP_ADD, 1, 2, 1'b1), RESP_OKAY);
      axiWr(REG_CMD, cmd(OP_ADD, 1, 3, 1'b1), RESP_OKAY);
      axiWr(REG_CMD, cmd(OP_ADD, 2, 1, 1'b1), RESP_OKAY);
      axiWr(REG_CMD, cmd(OP_ADD, 2, 3, 1'b1), RESP_OKAY);
      rdChk(REG_STAT, RESP_OKAY, 32'h00000403, 32'hffffffff);
      beat(1, 8'h11, 1'b0, 8'h00);
      axiWr(REG_CMD, cmd(OP_SAVE, 0, 0, 1'b0), RESP_OKAY);
      rdChk(REG_STAT, RESP_OKAY, 32'h00040400, 32'h000f0f02);
      beat(1, 8'h22, 1'b0, 8'h0c);
      beat(2, 8'h33, 1'b0, 8'h0a);
      beat(5, 8'h44, 1'b0, 8'h00);
      axiWr(REG_CMD, cmd(OP_ADD, 1, 2, 1'b1), RESP_OKAY);
      rdChk(REG_STAT, RESP_OKAY, 32'h0, 32'h1);
      axiWr(REG_CMD, cmd(OP_ERR, 2, 0, 1'b0), RESP_OKAY);
      rdChk(REG_ERRMAP, RESP_OKAY, 32'hff, 32'hff);
      axiWr(REG_CMD, cmd(OP_SAVE, 0, 0, 1'b0), RESP_OKAY);
      rdChk(REG_ERRMAP, RESP_OKAY, 32'hfb, 32'hff);
      beat(2, 8'h55, 1'b1, 8'h00);
      beat(1, 8'h66, 1'b1, 8'h0c);
      beat(2, 8'h77, 1'b0, 8'h0a);
      axiWr(REG_CMD, cmd(OP_DEL, 1, 3, 1'b0), RESP_OKAY);
      axiWr(REG_CMD, cmd(OP_SAVE, 0, 0, 1'b0), RESP_OKAY);
      beat(1, 8'h88, 1'b0, 8'h04);
      axiWr(REG_CMD, cmd(OP_DEL, 1, 3, 1'b0), RESP_OKAY);
      rdChk(REG_STAT, RESP_OKAY, 32'h0, 32'h1);
      // source 3 has no entries yet: its first add must turn error-copy back on
      axiWr(REG_CMD, cmd(OP_ERR, 3, 0, 1'b0), RESP_OKAY);
      for (int i = 0; i < 5; i++) begin
         axiWr(REG_CMD, cmd(OP_ADD, 3, i, 1'b1), RESP_OKAY);
      end
      axiWr(REG_CMD, cmd(OP_ADD, 3, 5, 1'b1), RESP_OKAY);
      rdChk(REG_STAT, RESP_OKAY, 32'h0, 32'h1);
      axiWr(REG_CMD, cmd(OP_SAVE, 0, 0, 1'b0), RESP_OKAY);
      rdChk(REG_STAT, RESP_OKAY, 32'h00080000, 32'h000f0000);
      rdChk(REG_ERRMAP, RESP_OKAY, 32'hfb, 32'hff);
      axiWr(REG_SEL, 32'h0, RESP_OKAY);
      rdChk(REG_ENTRY, RESP_OKAY, 32'h80000000, 32'h80000000);
      axiWr(REG_CTRL, 32'h2, RESP_OKAY);
      rdChk(REG_CTRL, RESP_OKAY, 32'h2, 32'h7);
      beat(1, 8'h99, 1'b0, 8'h00);
      axiWr(REG_CTRL, 32'h1, RESP_OKAY);
      rdChk(REG_CTRL, RESP_OKAY, 32'h5, 32'h7);
      // a write with no byte lane enabled must leave the mode alone
      s_axi_wstrb <= 4'h0;
      axiWr(REG_CTRL, 32'h2, RESP_OKAY);
      rdChk(REG_CTRL, RESP_OKAY, 32'h5, 32'h7);
      beat(1, 8'haa, 1'b0, 8'h04);
      // egress stalled: the queue plus the output register must refuse the next beat
      @(posedge clk);
      stall     <= 1'b1;
      acc = 0;
      rxValid   <= 1'b1;
      rxSrcPort <= 3'h3;
      rxLast    <= 1'b0;
      rxData    <= 8'h00;
      for (int i = 0; i < 24; i++) begin
         @(negedge clk);
         if (rxReady === 1'b1) acc++;
         @(posedge clk);
         rxData <= acc[7:0];
      end
      rxValid <= 1'b0;
      stall   <= 1'b0;
      chk("accepted", FIFO_DEPTH + 1, acc);
      for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
         waitBeat();
         chk("drain", {15'h0, 1'b0, 8'h1f, i[7:0]}, {15'h0, gotLast, gotMask, gotData});
      end
      end_sim();
   end

   initial begin
      repeat (6000) @(posedge clk);
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire

// ===== ptm_pkg.sv
// constants and types shared by the port traffic mirror design
`default_nettype none
package ptm_pkg;
   localparam int NUM_PORTS   = 8;
   localparam int PORT_W      = 3;
   localparam int TABLE_DEPTH = 8;
   localparam int IDX_W       = 3;
   localparam int CNT_W       = 4;
   localparam int DATA_W      = 8;
   localparam int FIFO_DEPTH  = 16;
   localparam int FIFO_W      = DATA_W + PORT_W + 2;
   localparam int ADDR_W      = 8;
   // register byte addresses
   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CMD    = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STAT   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_SEL    = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_ENTRY  = 8'h10;
   localparam logic [ADDR_W-1:0] REG_ERRMAP = 8'h14;
   // field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int MODE_W        = 2;
   localparam int CTRL_AVAIL_B  = 2;
   localparam int CMD_SRC_LSB   = 0;
   localparam int CMD_DST_LSB   = 4;
   localparam int CMD_ERR_B     = 8;
   localparam int CMD_OP_LSB    = 12;
   localparam int OP_W          = 3;
   localparam int STAT_OK_B     = 0;
   localparam int STAT_PEND_B   = 1;
   localparam int STAT_STG_LSB  = 8;
   localparam int STAT_ACT_LSB  = 16;
   localparam int ENT_SRC_LSB   = 0;
   localparam int ENT_DST_LSB   = 8;
   localparam int ENT_VALID_B   = 31;
   typedef enum logic [OP_W-1:0] {
      OP_NONE = 3'h0, OP_ADD = 3'h1, OP_DEL = 3'h2, OP_ERR = 3'h3, OP_SAVE = 3'h4
   } ptm_op_t;
   typedef enum logic [MODE_W-1:0] {
      MODE_BRIDGE = 2'h0, MODE_TRUNK = 2'h1, MODE_TAGGED = 2'h3, MODE_SPARE = 2'h2
   } ptm_mode_t;
   // one bit per mode value: modes in which mirroring is offered
   localparam logic [3:0] MIRROR_MODES = 4'h3;
   localparam ptm_mode_t MODE_RESET = MODE_BRIDGE;
   localparam logic [NUM_PORTS-1:0] ERR_COPY_RESET = 8'hff;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== ptm_sink_model.sv
// model of the switch egress datapath that takes beats and their mirror masks
`timescale 1ns/1ps
`default_nettype none
module ptm_sink_model (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          slow,
   input  wire logic                          stall,
   input  wire logic                          txValid,
   output logic                               txReady,
   input  wire logic [ptm_pkg::DATA_W-1:0]    txData,
   input  wire logic [ptm_pkg::PORT_W-1:0]    txSrcPort,
   input  wire logic                          txLast,
   input  wire logic                          txError,
   input  wire logic [ptm_pkg::NUM_PORTS-1:0] txMirrorMask,
   output logic                               gotBeat,
   output logic      [ptm_pkg::DATA_W-1:0]    gotData,
   output logic      [ptm_pkg::PORT_W-1:0]    gotSrc,
   output logic                               gotLast,
   output logic                               gotErr,
   output logic      [ptm_pkg::NUM_PORTS-1:0] gotMask
);
   import ptm_pkg::*;
   logic readyTgl_q;

   // slow mode takes a beat only every other cycle, so the output register must hold
   assign txReady = !stall && (!slow || readyTgl_q);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         readyTgl_q <= 1'b0;
      end else begin
         readyTgl_q <= !readyTgl_q;
      end
   end

   // normal forwarding keys on the source port; the mask only adds copies
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gotBeat <= 1'b0;
         gotData <= '0;
         gotSrc  <= '0;
         gotLast <= 1'b0;
         gotErr  <= 1'b0;
         gotMask <= '0;
      end else begin
         gotBeat <= txValid && txReady;
         if (txValid && txReady) begin
            gotData <= txData;
            gotSrc  <= txSrcPort;
            gotLast <= txLast;
            gotErr  <= txError;
            gotMask <= txMirrorMask;
         end
      end
   end
endmodule
`default_nettype wire

// ===== ptm_top.sv
// port traffic mirror: table, error-copy settings, axi4-lite registers and frame path
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
//---------------------------------------------------------------
// Overview of operation
// - any port may be a source; one source may have several destinations
// - each beat from a source carries that source's destination mask, except in non-mirror modes or when errored with error-copy off
// - a port may be source and destination of other sources at once
// - frames always pass to normal forwarding, mirroring only adds a mask
// - per-source error-copy bit: off clears the mask of errored frames
// - error-copy is on after reset and for a source's first entry
// - add or delete commands insert or remove exactly the given pair
// - edits are staged; save commits all at once and exposes the lists
// - mirroring only works in operational modes that support it
//---------------------------------------------------------------

//---------------------------------------------------------------
// fifo
//---------------------------------------------------------------
module ptm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             wrValid,
   output logic                  wrReady,
   input  wire logic [WIDTH-1:0] wrData,
   output logic                  rdValid,
   input  wire logic             rdReady,
   output logic      [WIDTH-1:0] rdData
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_q;
   logic [PW-1:0]    rdPtr_q;
   logic [PW:0]      count_q;
   logic             notFull_q;
   logic             emptyQ_q;
   logic             push;
   logic             pop;
   logic [PW:0]      countNext;

   assign push      = wrValid && notFull_q;
   assign pop       = rdReady && !emptyQ_q;
   assign wrReady   = notFull_q;
   assign rdValid   = !emptyQ_q;
   assign rdData    = mem[rdPtr_q];
   assign countNext = count_q + (PW+1)'(push) - (PW+1)'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= wrData;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_q  <= '0;
         rdPtr_q  <= '0;
         count_q  <= '0;
         notFull_q <= 1'b1;
         emptyQ_q <= 1'b1;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         count_q  <= countNext;
         notFull_q <= (countNext != (PW+1)'(DEPTH));
         emptyQ_q <= (countNext == '0);
      end
   end
endmodule

//---------------------------------------------------------------
// top
//---------------------------------------------------------------
module ptm_top (
   input  wire logic                         clk,
   input  wire logic                         reset_n,
   input  wire logic [ptm_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic      [1:0]                   s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [ptm_pkg::ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic      [31:0]                  s_axi_rdata,
   output logic      [1:0]                   s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   input  wire logic                         rxValid,
   output logic                              rxReady,
   input  wire logic [ptm_pkg::DATA_W-1:0]   rxData,
   input  wire logic [ptm_pkg::PORT_W-1:0]   rxSrcPort,
   input  wire logic                         rxLast,
   input  wire logic                         rxError,
   output logic                              txValid,
   input  wire logic                         txReady,
   output logic      [ptm_pkg::DATA_W-1:0]   txData,
   output logic      [ptm_pkg::PORT_W-1:0]   txSrcPort,
   output logic                              txLast,
   output logic                              txError,
   output logic      [ptm_pkg::NUM_PORTS-1:0] txMirrorMask
);
   import ptm_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // staged and active copies of the table
   logic              stgValid_q [TABLE_DEPTH];
   logic [PORT_W-1:0] stgSrc_q   [TABLE_DEPTH];
   logic [PORT_W-1:0] stgDst_q   [TABLE_DEPTH];
   logic              actValid_q [TABLE_DEPTH];
   logic [PORT_W-1:0] actSrc_q   [TABLE_DEPTH];
   logic [PORT_W-1:0] actDst_q   [TABLE_DEPTH];
   logic [NUM_PORTS-1:0] stgErr_q;
   logic [NUM_PORTS-1:0] actErr_q;
   ptm_mode_t         mode_q;
   logic [IDX_W-1:0]  sel_q;
   logic              cmdOk_q;
   logic              pending_q;

   function automatic logic [IDX_W:0] findPair(input logic [PORT_W-1:0] s, input logic [PORT_W-1:0] d);
      logic [IDX_W:0] r;
      r = '0;
      for (int i = TABLE_DEPTH-1; i >= 0; i--) begin
         if (stgValid_q[i] && stgSrc_q[i] == s && stgDst_q[i] == d) begin
            r = {1'b1, IDX_W'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [IDX_W:0] findFree();
      logic [IDX_W:0] r;
      r = '0;
      for (int i = TABLE_DEPTH-1; i >= 0; i--) begin
         if (!stgValid_q[i]) begin
            r = {1'b1, IDX_W'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [NUM_PORTS-1:0] destMask(input logic [PORT_W-1:0] s);
      logic [NUM_PORTS-1:0] m;
      m = '0;
      for (int i = 0; i < TABLE_DEPTH; i++) begin
         if (actValid_q[i] && actSrc_q[i] == s) begin
            m[actDst_q[i]] = 1'b1;
         end
      end
      return m;
   endfunction

   function automatic logic [CNT_W-1:0] countValid(input logic v [TABLE_DEPTH]);
      logic [CNT_W-1:0] c;
      c = '0;
      for (int i = 0; i < TABLE_DEPTH; i++) begin
         c = c + CNT_W'(v[i]);
      end
      return c;
   endfunction

   //---------------------------------------------------------------
   // axi4-lite slave
   //---------------------------------------------------------------
   logic [ADDR_W-1:0] awAddr_q;
   logic [31:0]       wData_q;
   logic [3:0]        wStrb_q;
   logic              wrFire;
   logic              addrOk;
   logic [31:0]       rdMux;
   logic              rdOk;

   assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign addrOk = awAddr_q == REG_CTRL || awAddr_q == REG_CMD || awAddr_q == REG_SEL;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awAddr_q      <= '0;
         wData_q       <= '0;
         wStrb_q       <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q      <= s_axi_wdata;
            wStrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wrFire) begin
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= addrOk ? RESP_OKAY : RESP_SLVERR;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rdMux = '0;
      rdOk  = 1'b1;
      case (s_axi_araddr)
         REG_CTRL: begin
            rdMux[CTRL_MODE_LSB +: MODE_W] = mode_q;
            rdMux[CTRL_AVAIL_B]            = MIRROR_MODES[mode_q];
         end
         REG_CMD: rdMux = '0;
         REG_STAT: begin
            rdMux[STAT_OK_B]                = cmdOk_q;
            rdMux[STAT_PEND_B]              = pending_q;
            rdMux[STAT_STG_LSB +: CNT_W]    = countValid(stgValid_q);
            rdMux[STAT_ACT_LSB +: CNT_W]    = countValid(actValid_q);
         end
         REG_SEL: rdMux[IDX_W-1:0] = sel_q;
         REG_ENTRY: begin
            rdMux[ENT_VALID_B]              = actValid_q[sel_q];
            rdMux[ENT_SRC_LSB +: PORT_W]    = actSrc_q[sel_q];
            rdMux[ENT_DST_LSB +: PORT_W]    = actDst_q[sel_q];
         end
         REG_ERRMAP: rdMux[NUM_PORTS-1:0] = actErr_q;
         default: rdOk = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdMux;
         s_axi_rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   //---------------------------------------------------------------
   // control registers and table commands
   //---------------------------------------------------------------
   logic              doWr;
   ptm_op_t           cmdOp;
   logic [PORT_W-1:0] cmdSrc;
   logic [PORT_W-1:0] cmdDst;
   logic [IDX_W:0]    hit;
   logic [IDX_W:0]    free;
   logic              srcKnown;
   logic              doCmd;

   // a write with no strobe lane set changes nothing
   assign doWr   = wrFire && (wStrb_q != '0);
   assign doCmd  = doWr && awAddr_q == REG_CMD;
   assign cmdOp  = ptm_op_t'(wData_q[CMD_OP_LSB +: OP_W]);
   assign cmdSrc = wData_q[CMD_SRC_LSB +: PORT_W];
   assign cmdDst = wData_q[CMD_DST_LSB +: PORT_W];

   // a process, not an assign: the searches read the staged table inside the functions
   always_comb begin
      hit  = findPair(cmdSrc, cmdDst);
      free = findFree();
   end

   always_comb begin
      srcKnown = 1'b0;
      for (int i = 0; i < TABLE_DEPTH; i++) begin
         srcKnown = srcKnown | (stgValid_q[i] && stgSrc_q[i] == cmdSrc);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= MODE_RESET;
         sel_q  <= '0;
      end else if (doWr && awAddr_q == REG_CTRL) begin
         mode_q <= ptm_mode_t'(wData_q[CTRL_MODE_LSB +: MODE_W]);
      end else if (doWr && awAddr_q == REG_SEL) begin
         sel_q <= wData_q[IDX_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < TABLE_DEPTH; i++) begin
            stgValid_q[i] <= 1'b0;
            stgSrc_q[i]   <= '0;
            stgDst_q[i]   <= '0;
            actValid_q[i] <= 1'b0;
            actSrc_q[i]   <= '0;
            actDst_q[i]   <= '0;
         end
         stgErr_q  <= ERR_COPY_RESET;
         actErr_q  <= ERR_COPY_RESET;
         cmdOk_q   <= 1'b0;
         pending_q <= 1'b0;
      end else if (doCmd) begin
         case (cmdOp)
            OP_ADD: begin
               // duplicate or full table leaves the staged table alone
               if (hit[IDX_W] || !free[IDX_W]) begin
                  cmdOk_q <= 1'b0;
               end else begin
                  stgValid_q[free[IDX_W-1:0]] <= 1'b1;
                  stgSrc_q[free[IDX_W-1:0]]   <= cmdSrc;
                  stgDst_q[free[IDX_W-1:0]]   <= cmdDst;
                  if (!srcKnown) begin
                     stgErr_q[cmdSrc] <= 1'b1;
                  end
                  cmdOk_q   <= 1'b1;
                  pending_q <= 1'b1;
               end
            end
            OP_DEL: begin
               cmdOk_q <= hit[IDX_W];
               if (hit[IDX_W]) begin
                  stgValid_q[hit[IDX_W-1:0]] <= 1'b0;
                  pending_q <= 1'b1;
               end
            end
            OP_ERR: begin
               stgErr_q[cmdSrc] <= wData_q[CMD_ERR_B];
               cmdOk_q   <= 1'b1;
               pending_q <= 1'b1;
            end
            OP_SAVE: begin
               for (int i = 0; i < TABLE_DEPTH; i++) begin
                  actValid_q[i] <= stgValid_q[i];
                  actSrc_q[i]   <= stgSrc_q[i];
                  actDst_q[i]   <= stgDst_q[i];
               end
               actErr_q  <= stgErr_q;
               cmdOk_q   <= 1'b1;
               pending_q <= 1'b0;
            end
            default: cmdOk_q <= 1'b0;
         endcase
      end
   end

   //---------------------------------------------------------------
   // frame path
   //---------------------------------------------------------------
   logic              fifoValid;
   logic              fifoTake;
   logic [FIFO_W-1:0] fifoData;
   logic              outLoad;
   logic [PORT_W-1:0] fSrc;
   logic              fErr;
   logic [NUM_PORTS-1:0] mirNext;

   assign outLoad  = !txValid || txReady;
   assign fifoTake = fifoValid && outLoad;
   assign fSrc     = fifoData[DATA_W +: PORT_W];
   assign fErr     = fifoData[FIFO_W-1];
   // mirror decision is taken at fifo output so a save affects frames already queued
   // a process so that a save, which only changes the active table, re-evaluates the mask
   always_comb begin
      mirNext = (MIRROR_MODES[mode_q] && (!fErr || actErr_q[fSrc])) ? destMask(fSrc) : '0;
   end

   ptm_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk     (clk),
      .reset_n (reset_n),
      .wrValid (rxValid),
      .wrReady (rxReady),
      .wrData  ({rxError, rxLast, rxSrcPort, rxData}),
      .rdValid (fifoValid),
      .rdReady (outLoad),
      .rdData  (fifoData)
   );

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txValid      <= 1'b0;
         txData       <= '0;
         txSrcPort    <= '0;
         txLast       <= 1'b0;
         txError      <= 1'b0;
         txMirrorMask <= '0;
      end else if (outLoad) begin
         txValid      <= fifoValid;
         txData       <= fifoData[DATA_W-1:0];
         txSrcPort    <= fSrc;
         txLast       <= fifoData[FIFO_W-2];
         txError      <= fErr;
         txMirrorMask <= mirNext;
      end
   end

   //---------------------------------------------------------------
   // checks
   //---------------------------------------------------------------
   chk_frame_passes: assert property (fifoTake |=> txValid && txData == $past(fifoData[DATA_W-1:0]))
      else $error("taken beat not presented");
   chk_mask_source: assert property (fifoTake && !fErr && MIRROR_MODES[mode_q] |=> txMirrorMask == $past(destMask(fSrc)))
      else $error("mirror mask mismatch");
   chk_err_drop: assert property (txValid && txError && !$past(actErr_q[fSrc]) && $past(fifoTake)
      |-> txMirrorMask == '0)
      else $error("errored frame mirrored");
   chk_mode_gate: assert property (fifoTake && !MIRROR_MODES[mode_q] |=> txMirrorMask == '0)
      else $error("mirror in unsupported mode");
   chk_full_refuse: assert property (doCmd && cmdOp == OP_ADD && (hit[IDX_W] || !free[IDX_W]) |=> !cmdOk_q && countValid(stgValid_q) == $past(countValid(stgValid_q)))
      else $error("refused add changed table");
   chk_add_one: assert property (doCmd && cmdOp == OP_ADD && !hit[IDX_W] && free[IDX_W] |=> findPair($past(cmdSrc), $past(cmdDst)) != '0 && countValid(stgValid_q) == $past(countValid(stgValid_q)) + 1'b1)
      else $error("add did not insert one pair");
   chk_new_src_err: assert property (doCmd && cmdOp == OP_ADD && !hit[IDX_W] && free[IDX_W] && !srcKnown |=> stgErr_q[$past(cmdSrc)])
      else $error("new source error-copy not on");
   chk_save_commit: assert property (doCmd && cmdOp == OP_SAVE |=> actErr_q == $past(stgErr_q) && countValid(actValid_q) == $past(countValid(stgValid_q)) && !pending_q)
      else $error("save did not commit");
endmodule
`default_nettype wire
